// *** pll_clock_reset_control.sv ***
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_reset_control
    import pll_clock_pkg::*;
#(
    parameter int INT_W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic crystal_input,
    input wire logic external_ref_clock_in,
    input wire logic clock_mode_sel_0,
    input wire logic clock_mode_sel_1,
    input wire logic device_reset_n,
    input wire logic output_float_n,
    input wire logic [INT_W-1:0] ext_int_n,
    input wire logic bus_busy,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic crystal_drive_output,
    output logic multiplier_power_on,
    output logic core_clock_tick,
    output logic phase_one_clock,
    output logic phase_three_clock,
    output logic cpu_reset_n,
    output logic bus_stop_request,
    output logic pin_output_enable
);
    // Pin synchronisers; float and interrupt pins idle high, the reset pin starts
    // asserted so a block reset never lets the CPU run before the pin is seen high
    logic [INT_W+6:0] pinsRaw, pinsSync;
    logic xtalS, extS, resetS, floatS;
    logic [1:0] modeS;
    logic [INT_W-1:0] intS;

    assign pinsRaw = {ext_int_n, output_float_n, device_reset_n, clock_mode_sel_1,
                      clock_mode_sel_0, external_ref_clock_in, crystal_input, 1'b0};

    sync2 #(
        .W(INT_W + 7),
        .INIT({{(INT_W + 1){1'b1}}, 6'h00})
    ) pinSync (
        .clock(clock),
        .rst_n(rst_n),
        .d(pinsRaw),
        .q(pinsSync)
    );

    assign xtalS = pinsSync[1];
    assign extS = pinsSync[2];
    assign modeS = pinsSync[4:3];
    assign resetS = pinsSync[5];
    assign floatS = pinsSync[6];
    assign intS = pinsSync[INT_W+6:7];

    function automatic modeCfg_t decode_mode(input logic [1:0] sel);
        modeCfg_t c;
        c.feedback = (sel != 2'h0);
        c.pllPower = (sel == 2'h3);
        c.ratio = ratio_t'(sel);
        decode_mode = c;
    endfunction

    modeCfg_t cfg;
    assign cfg = decode_mode(modeS);

    // Reference path
    logic refLevel, refPrev_r, refEdge;
    assign refLevel = xtalS ^ extS;
    assign refEdge = refLevel & ~refPrev_r;

    logic resetPrev_r, resetFall;
    assign resetFall = resetPrev_r & ~resetS;

    // Multiplier
    logic x5Tick, multLocked;
    ref_multiplier #(
        .PW(PERIOD_W)
    ) mult (
        .clock(clock),
        .rst_n(rst_n),
        .enable(cfg.pllPower),
        .refEdge(refEdge),
        .tick(x5Tick),
        .locked(multLocked)
    );

    // Lock counter and rate select
    logic [LOCK_W-1:0] lockCnt_r;
    logic lockDone_r, useX5_r, halfToggle_r;
    logic lockStep;
    assign lockStep = refEdge & resetS & ~lockDone_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            refPrev_r <= 1'b0;
            resetPrev_r <= 1'b0;
            halfToggle_r <= 1'b0;
            lockCnt_r <= '0;
            lockDone_r <= 1'b0;
            useX5_r <= 1'b0;
        end else begin
            refPrev_r <= refLevel;
            resetPrev_r <= resetS;
            if (refEdge) begin
                halfToggle_r <= ~halfToggle_r;
                // Select only moves on a reference edge, so no runt tick
                useX5_r <= lockDone_r & multLocked;
            end
            if (lockStep) begin
                if (lockCnt_r == LOCK_LAST) begin
                    lockCnt_r <= '0;
                    lockDone_r <= 1'b1;
                end else begin
                    lockCnt_r <= lockCnt_r + 1'b1;
                end
            end
        end
    end

    logic halfTick, baseTick;
    assign halfTick = refEdge & halfToggle_r;
    assign baseTick = (cfg.ratio == RATIO_HALF) ? halfTick :
                      (cfg.ratio == RATIO_FIVE) ? (useX5_r ? x5Tick : halfTick) :
                      refEdge;

    // Software divider, legacy half and phase clocks
    divMode_t divMode_r;
    logic legacy_r, legacyTog_r, coreTick_r, phaseOne_r, phaseThree_r;
    logic [3:0] subDiv_r;
    logic stopped, wakeUp, gatedTick, coreTickNxt;
    logic ctrlWrite;
    logic [31:0] wdataWord;

    assign stopped = (divMode_r == DIV_STOP);
    assign wakeUp = stopped & (~resetS | ~(&intS));
    assign gatedTick = baseTick & ~stopped &
                       ((divMode_r != DIV_SIXTEENTH) | (subDiv_r == 4'h0));
    assign coreTickNxt = gatedTick & (~legacy_r | legacyTog_r);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divMode_r <= DIV_FULL;
            legacy_r <= CTRL_RESET[CTRL_LEGACY_BIT];
            legacyTog_r <= 1'b0;
            subDiv_r <= 4'h0;
            coreTick_r <= 1'b0;
            phaseOne_r <= 1'b0;
            phaseThree_r <= 1'b1;
        end else begin
            // Hardware clear beats a software write in the same cycle
            if (resetFall | wakeUp) begin
                divMode_r <= DIV_FULL;
            end else if (ctrlWrite) begin
                divMode_r <= (wdataWord[CTRL_DIV_LSB+:2] == 2'h3) ? DIV_FULL :
                             divMode_t'(wdataWord[CTRL_DIV_LSB+:2]);
            end
            if (ctrlWrite) begin
                legacy_r <= wdataWord[CTRL_LEGACY_BIT];
            end
            if (resetFall) begin
                subDiv_r <= 4'h0;
                legacyTog_r <= phaseOne_r;
            end else begin
                if (baseTick) begin
                    subDiv_r <= subDiv_r + 1'b1;
                end
                if (gatedTick) begin
                    legacyTog_r <= ~legacyTog_r;
                end
            end
            coreTick_r <= coreTickNxt;
            if (coreTickNxt) begin
                phaseOne_r <= ~phaseOne_r;
                phaseThree_r <= phaseOne_r;
            end
        end
    end

    // Reset sequencer
    seqState_t seq_r, seqNxt;
    logic [3:0] drainCnt_r;
    logic busOe_r, cpuRun_r, drainDone;
    assign drainDone = ~bus_busy | (drainCnt_r == DRAIN_MAX);

    always_comb begin
        seqNxt = seq_r;
        unique case (seq_r)
            SEQ_RUN: begin
                if (!resetS) begin
                    seqNxt = floatS ? SEQ_DRAIN : SEQ_QUIET;
                end
            end
            SEQ_DRAIN: begin
                if (!floatS || drainDone) begin
                    seqNxt = SEQ_QUIET;
                end
            end
            SEQ_QUIET: begin
                if (resetS) begin
                    seqNxt = SEQ_RUN;
                end
            end
            default: seqNxt = SEQ_QUIET;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seq_r <= SEQ_QUIET;
            drainCnt_r <= 4'h0;
            busOe_r <= 1'b0;
            cpuRun_r <= 1'b0;
        end else begin
            seq_r <= seqNxt;
            busOe_r <= (seqNxt != SEQ_QUIET);
            cpuRun_r <= (seqNxt == SEQ_RUN);
            if (seq_r != SEQ_DRAIN) begin
                drainCnt_r <= 4'h0;
            end else if (coreTick_r && drainCnt_r != DRAIN_MAX) begin
                drainCnt_r <= drainCnt_r + 1'b1;
            end
        end
    end

    // Outputs; the float pin gates directly so it needs no clock
    logic xtalDrive_r, powerOn_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xtalDrive_r <= 1'b0;
            powerOn_r <= 1'b0;
        end else begin
            xtalDrive_r <= cfg.feedback & ~xtalS;
            powerOn_r <= cfg.pllPower;
        end
    end

    assign crystal_drive_output = xtalDrive_r;
    assign multiplier_power_on = powerOn_r;
    assign core_clock_tick = coreTick_r;
    assign phase_one_clock = phaseOne_r;
    assign phase_three_clock = phaseThree_r;
    assign cpu_reset_n = cpuRun_r;
    assign bus_stop_request = (seq_r == SEQ_DRAIN);
    assign pin_output_enable = busOe_r & output_float_n;

    // AHB-Lite slave, zero wait states, always OKAY
    logic wrPend_r;
    logic [ADDR_W-1:0] wrAddr_r;
    logic [31:0] hrdata_r;
    logic addrTake;
    logic [ADDR_W-1:0] addrLow;
    logic [31:0] ctrlWord, statusWord, readWord;

    assign addrTake = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign addrLow = haddr[ADDR_W-1:0];
    assign wdataWord = hwdata;
    assign ctrlWrite = wrPend_r & (wrAddr_r == CTRL_OFFSET);
    assign ctrlWord = {29'h0, legacy_r, divMode_r};
    assign statusWord = {17'h0, seq_r, modeS, stopped, multLocked, lockDone_r, lockCnt_r};
    assign readWord = (addrLow == CTRL_OFFSET) ? ctrlWord :
                      (addrLow == STATUS_OFFSET) ? statusWord : 32'h0;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= '0;
            hrdata_r <= 32'h0;
        end else begin
            wrPend_r <= addrTake & hwrite;
            if (addrTake) begin
                wrAddr_r <= addrLow;
            end
            if (addrTake && !hwrite) begin
                hrdata_r <= readWord;
            end
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    logic hsizeUnused;
    assign hsizeUnused = ^hsize;

    chk_mode_power: assert property (@(posedge clock) disable iff (!rst_n)
        (cfg.pllPower && !hsizeUnused) || cfg.pllPower |=> multiplier_power_on)
        else $error("multiplier power not on in times-five mode");
    chk_ref_xor: assert property (@(posedge clock) disable iff (!rst_n)
        refEdge |-> (xtalS ^ extS) && !$past(xtalS ^ extS))
        else $error("reference edge not from XOR of sources");
    chk_stop_tick: assert property (@(posedge clock) disable iff (!rst_n)
        stopped |=> !coreTick_r)
        else $error("core tick while clock stopped");
    chk_wake_idle: assert property (@(posedge clock) disable iff (!rst_n)
        wakeUp |=> divMode_r == DIV_FULL)
        else $error("stopped clock did not wake");
    chk_lock_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !resetS |=> $stable(lockCnt_r))
        else $error("lock counter moved while reset low");
    chk_lock_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        lockDone_r |=> lockDone_r && lockCnt_r == '0)
        else $error("lock counter left cleared state");
    chk_half_rate: assert property (@(posedge clock) disable iff (!rst_n)
        (cfg.ratio == RATIO_FIVE && !lockDone_r) |-> !useX5_r)
        else $error("times-five used before lock count done");
    chk_drain_bound: assert property (@(posedge clock) disable iff (!rst_n)
        (seq_r == SEQ_DRAIN && drainCnt_r == DRAIN_MAX) |=> seq_r == SEQ_QUIET)
        else $error("drain exceeded ten cycles");
    chk_float_async: assert property (@(posedge clock) disable iff (!rst_n)
        !output_float_n |-> !pin_output_enable)
        else $error("outputs enabled while float pin low");
    chk_both_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (seq_r == SEQ_RUN && !resetS && !floatS) |=> seq_r == SEQ_QUIET ##1 !busOe_r)
        else $error("reset with float did not quiet at once");
    chk_clear_fall: assert property (@(posedge clock) disable iff (!rst_n)
        resetFall |=> divMode_r == DIV_FULL && subDiv_r == 4'h0)
        else $error("divider not cleared on reset fall");

    cov_lock_done: cover property (@(posedge clock) disable iff (!rst_n) $rose(lockDone_r));
    cov_x5_switch: cover property (@(posedge clock) disable iff (!rst_n) $rose(useX5_r));
    cov_drain: cover property (@(posedge clock) disable iff (!rst_n)
        seq_r == SEQ_DRAIN ##1 seq_r == SEQ_QUIET);
    cov_wake: cover property (@(posedge clock) disable iff (!rst_n) wakeUp);
endmodule
`default_nettype wire

// *** pll_clock_pkg.sv ***
package pll_clock_pkg;

    // Register map (byte addresses on the AHB-Lite slave)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

    // Control register fields
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_LEGACY_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Status register fields
    localparam int STAT_LOCKCNT_LSB = 0;
    localparam int STAT_LOCKDONE_BIT = 8;
    localparam int STAT_MULTLOCK_BIT = 9;
    localparam int STAT_STOPPED_BIT = 10;
    localparam int STAT_MODE_LSB = 11;
    localparam int STAT_SEQ_LSB = 13;

    // Multiplier and lock counter
    localparam int MULT_FACTOR = 5;
    localparam int LOCK_W = 8;
    localparam logic [LOCK_W-1:0] LOCK_LAST = 8'hff;
    localparam int PERIOD_W = 16;

    // Reset drain limit in CPU cycles
    localparam logic [3:0] DRAIN_MAX = 4'ha;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        DIV_FULL = 2'h0,
        DIV_SIXTEENTH = 2'h1,
        DIV_STOP = 2'h2
    } divMode_t;

    typedef enum logic [1:0] {
        RATIO_STATIC = 2'h0,
        RATIO_HALF = 2'h1,
        RATIO_ONE = 2'h2,
        RATIO_FIVE = 2'h3
    } ratio_t;

    typedef struct packed {
        logic feedback;
        logic pllPower;
        ratio_t ratio;
    } modeCfg_t;

    typedef enum logic [1:0] {
        SEQ_RUN = 2'h0,
        SEQ_DRAIN = 2'h1,
        SEQ_QUIET = 2'h3
    } seqState_t;

endpackage

// *** sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule
`default_nettype wire

// *** ref_multiplier.sv ***
`timescale 1ns/1ps
`default_nettype none
module ref_multiplier
    import pll_clock_pkg::*;
#(
    parameter int PW = PERIOD_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic refEdge,
    output logic tick,
    output logic locked
);
    logic [PW-1:0] cnt_r, period_r, sub_r;
    logic [2:0] burst_r;
    logic locked_r, tick_r;
    logic [PW-1:0] stepRaw;
    logic [PW-1:0] stepLen;
    logic cntFull;

    // Lock means two successive reference periods agree within one cycle
    function automatic logic near(input logic [PW-1:0] a, input logic [PW-1:0] b);
        near = (a == b) || (a == b + 1'b1) || (a + 1'b1 == b);
    endfunction

    assign stepRaw = period_r / PW'(MULT_FACTOR);
    assign stepLen = (stepRaw == '0) ? PW'(1) : stepRaw;
    assign cntFull = &cnt_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            period_r <= '0;
            sub_r <= '0;
            burst_r <= '0;
            locked_r <= 1'b0;
            tick_r <= 1'b0;
        end else if (!enable) begin
            cnt_r <= '0;
            period_r <= '0;
            locked_r <= 1'b0;
            tick_r <= 1'b0;
            burst_r <= '0;
        end else if (refEdge) begin
            cnt_r <= PW'(1);
            period_r <= cnt_r;
            locked_r <= near(cnt_r, period_r) && (cnt_r != '0);
            sub_r <= PW'(1);
            burst_r <= 3'h1;
            tick_r <= locked_r;
        end else begin
            if (!cntFull) begin
                cnt_r <= cnt_r + 1'b1;
            end else begin
                // Reference vanished: drop lock and reacquire
                locked_r <= 1'b0;
            end
            if (burst_r < 3'(MULT_FACTOR) && sub_r >= stepLen) begin
                sub_r <= PW'(1);
                burst_r <= burst_r + 1'b1;
                tick_r <= locked_r;
            end else begin
                sub_r <= sub_r + 1'b1;
                tick_r <= 1'b0;
            end
        end
    end

    assign tick = tick_r;
    assign locked = locked_r;
endmodule
`default_nettype wire

// *** ref_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ref_source_model #(
    parameter int HALF = 10
) (
    input wire logic clock,
    input wire logic run,
    input wire logic wantReset,
    input wire logic wantFloat,
    output logic crystal_input,
    output logic external_ref_clock_in,
    output logic device_reset_n,
    output logic output_float_n
);
    int phase = 0;
    int holdOff = 0;
    logic refLvl = 1'b0;
    logic resetLvl = 1'b0;
    logic floatLvl = 1'b1;
    assign crystal_input = 1'b0;
    assign external_ref_clock_in = refLvl;
    assign device_reset_n = resetLvl;
    assign output_float_n = floatLvl;
    // Reference stands still while run is low, so the lock counter sees no clock
    always @(posedge clock) begin
        if (run) begin
            phase <= (phase == HALF - 1) ? 0 : phase + 1;
            if (phase == HALF - 1) begin
                refLvl <= ~refLvl;
            end
        end
    end
    // Float is let go first; reset rises only after a margin of 64 clock cycles
    always @(posedge clock) begin
        floatLvl <= ~wantFloat;
        if (wantReset) begin
            resetLvl <= 1'b0;
            holdOff <= 64;
        end else if (wantFloat) begin
            holdOff <= 64;
        end else if (holdOff > 0) begin
            holdOff <= holdOff - 1;
        end else begin
            resetLvl <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** test_pll_clock_reset_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_pll_clock_reset_control import pll_clock_pkg::*; ;
    logic clock, rst_n, modeSel0, modeSel1, busBusy, hsel, hwrite, run, wantReset, wantFloat;
    logic [3:0] extIntN;
    logic [31:0] haddr, hwdata, rdv, a;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic xtalIn, extRef, devResetN, floatN, hreadyout, hresp, xtalDrive, multPower;
    wire logic coreTick, phaseOne, phaseThree, cpuResetN, busStop, pinOe;
    wire logic [31:0] hrdata;
    int nFail = 0, samplesChecked = 0, ticks = 0, t0, k;

    ref_source_model u_ref (.clock(clock), .run(run), .wantReset(wantReset),
        .wantFloat(wantFloat), .crystal_input(xtalIn), .external_ref_clock_in(extRef),
        .device_reset_n(devResetN), .output_float_n(floatN));
    pll_clock_reset_control u_dut (.clock(clock), .rst_n(rst_n), .crystal_input(xtalIn),
        .external_ref_clock_in(extRef), .clock_mode_sel_0(modeSel0),
        .clock_mode_sel_1(modeSel1), .device_reset_n(devResetN), .output_float_n(floatN),
        .ext_int_n(extIntN), .bus_busy(busBusy), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .crystal_drive_output(xtalDrive), .multiplier_power_on(multPower),
        .core_clock_tick(coreTick), .phase_one_clock(phaseOne),
        .phase_three_clock(phaseThree), .cpu_reset_n(cpuResetN),
        .bus_stop_request(busStop), .pin_output_enable(pinOe));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) if (coreTick === 1'b1) ticks <= ticks + 1;

    task automatic closeOut();
        if (nFail == 0 && samplesChecked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
        samplesChecked++;
        if (s !== e) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic bound(input int lim);
        if (k >= lim) begin
            nFail++;
            closeOut();
        end
    endtask
    // Address phase held until hready, then data phase held until hready again
    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsize <= 3'h2;
        k = 0;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
        bound(50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        k = 0;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
        bound(50);
        rdv = hrdata;
        chk("hresp", hresp, HRESP_OKAY);
    endtask
    task automatic waitRun();
        k = 0;
        while (cpuResetN !== 1'b1 && k < 300) begin @(posedge clock); k++; end
        bound(300);
        repeat (40) @(posedge clock);
    endtask
    task automatic window(input int cyc, input int e, input string w);
        t0 = ticks;
        repeat (cyc) @(posedge clock);
        chk(w, ticks - t0, e);
    endtask

    task automatic resetValues();
        ahb(1'b0, CTRL_OFFSET, 32'h0);
        chk("ctrl reset", rdv, {29'h0, CTRL_RESET});
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        chk("mode and sequencer", rdv[14:11], 4'hf);
        chk("power", {multPower, xtalDrive, cpuResetN}, 3'h6);
    endtask
    task automatic lockRamp();
        run <= 1'b1;
        repeat (100) @(posedge clock);
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        a = rdv;
        repeat (200) @(posedge clock);
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        chk("lock count held", rdv[7:0], a[7:0]);
        wantReset <= 1'b0;
        waitRun();
        window(80, 2, "half rate ticks");
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        chk("lock done early", rdv[8], 1'b0);
        k = 0;
        do begin
            repeat (20) @(posedge clock);
            ahb(1'b0, STATUS_OFFSET, 32'h0);
            k++;
        end while (rdv[9:8] !== 2'h3 && k < 400);
        bound(400);
        repeat (40) @(posedge clock);
        window(80, 20, "x5 ticks");
    endtask
    task automatic dividerModes();
        logic [2:0] cv[5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h0};
        int ev[5] = '{5, 0, 40, 80, 80};
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, CTRL_OFFSET, {29'h0, cv[i]});
            repeat (64) @(posedge clock);
            window(320, ev[i], "divided ticks");
            ahb(1'b0, STATUS_OFFSET, 32'h0);
            chk("stopped flag", rdv[10], cv[i] == 3'h2);
            chk("phase pair", phaseOne ^ phaseThree, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, CTRL_OFFSET, 32'h2);
            extIntN[i] <= 1'b0;
            repeat (5) @(posedge clock);
            extIntN[i] <= 1'b1;
            ahb(1'b0, STATUS_OFFSET, 32'h0);
            chk("woken", rdv[10], 1'b0);
        end
    endtask
    task automatic mapAccess();
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        a = rdv;
        ahb(1'b1, STATUS_OFFSET, 32'hffffffff);
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        chk("status read only", rdv, a);
        ahb(1'b1, 8'h08, 32'h5);
        ahb(1'b0, 8'h08, 32'h0);
        chk("unmapped", rdv, 32'h0);
    endtask
    task automatic resetDrain();
        busBusy <= 1'b1;
        ahb(1'b1, CTRL_OFFSET, 32'h1);
        wantReset <= 1'b1;
        k = 0;
        while (busStop !== 1'b1 && k < 20) begin @(posedge clock); k++; end
        bound(20);
        t0 = ticks;
        chk("oe in drain", pinOe, 1'b1);
        k = 0;
        while (pinOe !== 1'b0 && k < 200) begin @(posedge clock); k++; end
        bound(200);
        chk("drain length", (ticks - t0 >= 9) && (ticks - t0 <= 11), 1'b1);
        chk("cpu held", cpuResetN, 1'b0);
        ahb(1'b0, CTRL_OFFSET, 32'h0);
        chk("divider cleared", rdv[1:0], 2'h0);
        busBusy <= 1'b0;
        wantReset <= 1'b0;
        waitRun();
        window(80, 20, "no second ramp");
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        chk("lock kept", rdv[9:8], 2'h3);
    endtask
    task automatic floatCases();
        wantFloat <= 1'b1;
        @(posedge clock);
        #1;
        chk("float alone", {pinOe, cpuResetN}, 2'h1);
        wantFloat <= 1'b0;
        repeat (5) @(posedge clock);
        chk("oe back", pinOe, 1'b1);
        wantFloat <= 1'b1;
        wantReset <= 1'b1;
        @(posedge clock);
        #1;
        chk("oe both", pinOe, 1'b0);
        repeat (8) @(posedge clock);
        chk("no drain", {busStop, cpuResetN}, 2'h0);
        wantFloat <= 1'b0;
        wantReset <= 1'b0;
        waitRun();
    endtask
    task automatic modeTable();
        for (int m = 0; m < 3; m++) begin
            rst_n <= 1'b0;
            modeSel0 <= m[0];
            modeSel1 <= m[1];
            repeat (2) @(posedge clock);
            rst_n <= 1'b1;
            waitRun();
            window(80, (m == 1) ? 2 : 4, "ratio ticks");
            chk("mode power", {multPower, xtalDrive}, {1'b0, m != 0});
        end
    endtask

    initial begin
        rst_n = 1'b0;
        modeSel0 = 1'b1;
        modeSel1 = 1'b1;
        extIntN = 4'hf;
        busBusy = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        run = 1'b0;
        wantReset = 1'b1;
        wantFloat = 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        resetValues();
        lockRamp();
        dividerModes();
        mapAccess();
        resetDrain();
        floatCases();
        modeTable();
        closeOut();
    end
endmodule
`default_nettype wire
